// ### rtl/adc_seq_pkg.sv
// Package with register map, field positions and timing constants of the converter sequencer.
package adc_seq_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_MODE      = 8'h00;
  localparam logic [7:0] OFF_CHANNEL   = 8'h04;
  localparam logic [7:0] OFF_PF_MODE   = 8'h08;
  localparam logic [7:0] OFF_PF_THRESH = 8'h0c;
  localparam logic [7:0] OFF_RESULT    = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;

  // Field positions.
  localparam int BIT_START     = 7;
  localparam int BIT_POWER     = 0;
  localparam int FR_HI         = 5;
  localparam int FR_LO         = 3;
  localparam int CH_HI         = 2;
  localparam int CH_LO         = 0;
  localparam int BIT_PF_ENABLE = 7;
  localparam int BIT_PF_DIR    = 6;
  localparam int BIT_FLAG      = 0;

  // Converter geometry.
  localparam int RES_BITS = 10;
  localparam int CNT_W    = 9;

  // Reset values.
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [2:0]  CH_RST     = 3'h0;
  localparam logic [7:0]  PFM_RST    = 8'h00;
  localparam logic [7:0]  PFT_RST    = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Extra start delay of the first conversion, in clock cycles.
  localparam logic [CNT_W-1:0] START_DELAY = 9'h020;

  // Sampling window is the conversion time divided by this.
  localparam logic [CNT_W-1:0] SAMPLE_DIV = 9'h006;

  // Implemented bits of the power-fail mode register; the rest read zero.
  localparam logic [7:0] PFM_MASK = 8'hc0;

  // Conversion cycles per time-select code; zero marks a prohibited code.
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] fr);
    case (fr)
      3'h0:    conv_cycles = 9'h120;
      3'h1:    conv_cycles = 9'h0f0;
      3'h2:    conv_cycles = 9'h0c0;
      3'h4:    conv_cycles = 9'h090;
      3'h5:    conv_cycles = 9'h078;
      3'h6:    conv_cycles = 9'h060;
      default: conv_cycles = 9'h000;
    endcase
  endfunction : conv_cycles

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV   = 4'b1000
  } seq_state_type;

endpackage : adc_seq_pkg

// ### rtl/adc_sar_core.sv
// Successive-approximation bit decision engine driven by the sequencer.
`timescale 1ns/1ps
module adc_sar_core
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Control from the sequencer.
  input  wire logic                clear,
  input  wire logic                step,
  // Comparator input and approximation value.
  input  wire logic                cmp_above,
  output logic [RES_BITS-1:0]      approx,
  output logic                     done
);
  import adc_seq_pkg::*;

  logic [RES_BITS-1:0] approx_q;
  logic [RES_BITS-1:0] trial_q;

  // Each step keeps or drops the trial bit and moves to the next lower bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      approx_q <= '0;
      trial_q  <= {1'b1, {(RES_BITS-1){1'b0}}};
    end
    else if (step && trial_q != '0)
    begin
      approx_q <= cmp_above ? (approx_q | trial_q) : approx_q;
      trial_q  <= trial_q >> 1;
    end
  end

  assign approx = approx_q;
  // Done once all ten decisions are taken.
  assign done   = (trial_q == '0);

endmodule : adc_sar_core

// ### rtl/adc_power_fail_sequencer.sv
// Converter sequencer with power-fail compare and AXI4-Lite register slave.
//Contract
// RL1 - Software waits 14 us power to start.
// RL2 - Channel and power may come either order.
// RL3 - Without power step, discard first result.
// RL4 - Later conversions take exactly selected time.
// RL5 - Power-fail setup order ends with start.
// RL6 - Power-fail: 14 us wait, steps any order.
// RL7 - Power-fail use needs explicit power step.
// RL8 - Power-fail compares upper byte with threshold.
// RL9 - Channel rewrite continues on new channel.
// RL10 - Stop clears start, then power enable.
// RL11 - Clearing start halts converter, saves current.
// RL12 - Result read served before result write.
// RL13 - Control write beats conversion end.
// RL14 - Channel write leaves end flag unchanged.
// RL15 - Clear end flag before resuming conversion.
// RL16 - Sampling lasts one sixth of conversion.
// RL17 - Early start: poll and discard first.
// RL18 - Avoid shared port access during conversion.
// RL19 - Direction 0 fires at-or-above, 1 below.
// RL20 - Conversions repeat while start stays set.
// RL21 - Register write aborts and restarts conversion.
// RL22 - After ten decisions, latch result.
// RL23 - Timing counted in main clock cycles.
// RL24 - Reset clears start, power, power-fail enable.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module adc_power_fail_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Analog front end.
  input  wire logic                       cmp_above,
  output logic [2:0]                      channel_field,
  output logic                            sample_switch,
  output logic                            converter_power_enable,
  output logic                            converter_busy,
  // Conversion end event.
  output logic                            conversion_end_irq
);
  import adc_seq_pkg::*;

  logic [7:0]          converter_mode_reg_q;
  logic [2:0]          channel_select_reg_q;
  logic [7:0]          power_fail_mode_reg_q;
  logic [7:0]          power_fail_threshold_reg_q;
  logic [15:0]         conversion_result_reg_q;
  logic                conversion_end_flag_q;
  logic                cmp_meta_q;
  logic                cmp_sync_q;
  seq_state_type       state_q;
  logic [CNT_W-1:0]    cnt_q;
  logic                first_q;
  logic                irq_q;
  logic                pend_q;
  logic [RES_BITS-1:0] pend_val_q;
  logic                have_aw_q;
  logic                have_w_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                wr_fire;
  logic                rd_fire;
  logic                ctl_write;
  logic                conv_write;
  logic                result_read;
  logic                seq_clear;
  logic                sar_step;
  logic                sar_done;
  logic                conv_end;
  logic                store_now;
  logic [RES_BITS-1:0] approx;
  logic [CNT_W-1:0]    total_cycles;
  logic [CNT_W-1:0]    sample_cycles;
  logic                conversion_start_bit;
  logic                power_fail_mode_enable;
  logic                compare_direction_bit;
  logic                cmp_hit;

  assign conversion_start_bit   = converter_mode_reg_q[BIT_START];
  assign converter_power_enable = converter_mode_reg_q[BIT_POWER];
  assign power_fail_mode_enable = power_fail_mode_reg_q[BIT_PF_ENABLE];
  assign compare_direction_bit  = power_fail_mode_reg_q[BIT_PF_DIR];
  assign channel_field          = channel_select_reg_q;

  // Comparator comes from the analog domain, so it is synchronised first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      cmp_meta_q <= cmp_above;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // Write channel: address and data are taken in either order, then answered.
  assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !have_w_q && !s_axi_bvalid;
  assign wr_fire       = have_aw_q && have_w_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw_q    <= 1'b0;
      have_w_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        have_aw_q    <= 1'b0;
        have_w_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= OFF_STATUS && awaddr_q[1:0] == 2'h0) ?
                        RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A write to any conversion-control register counts as a control write.
  assign ctl_write  = wr_fire && wstrb_q[0] &&
                      (awaddr_q == OFF_MODE || awaddr_q == OFF_CHANNEL ||
                       awaddr_q == OFF_PF_MODE || awaddr_q == OFF_PF_THRESH);
  assign conv_write = wr_fire && wstrb_q[0] &&
                      (awaddr_q == OFF_MODE || awaddr_q == OFF_CHANNEL);

  // Control registers; reset leaves the converter stopped and unpowered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      converter_mode_reg_q       <= MODE_RST; // [RL24]
      channel_select_reg_q       <= CH_RST;
      power_fail_mode_reg_q      <= PFM_RST; // [RL24]
      power_fail_threshold_reg_q <= PFT_RST;
    end
    else if (ctl_write)
    begin
      case (awaddr_q)
        OFF_MODE:      converter_mode_reg_q       <= wdata_q[7:0];
        OFF_CHANNEL:   channel_select_reg_q       <= wdata_q[CH_HI:CH_LO]; // [RL9]
        OFF_PF_MODE:   power_fail_mode_reg_q      <= wdata_q[7:0] & PFM_MASK;
        OFF_PF_THRESH: power_fail_threshold_reg_q <= wdata_q[7:0];
        default:       converter_mode_reg_q       <= converter_mode_reg_q;
      endcase
    end
  end

  // Read channel; a result read in the same cycle as a store sees the old value.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign result_read   = rd_fire && s_axi_araddr == OFF_RESULT;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_MODE:      s_axi_rdata <= {24'h000000, converter_mode_reg_q};
        OFF_CHANNEL:   s_axi_rdata <= {29'h00000000, channel_select_reg_q};
        OFF_PF_MODE:   s_axi_rdata <= {24'h000000, power_fail_mode_reg_q};
        OFF_PF_THRESH: s_axi_rdata <= {24'h000000, power_fail_threshold_reg_q};
        OFF_RESULT:    s_axi_rdata <= {16'h0000, conversion_result_reg_q}; // [RL12]
        OFF_STATUS:    s_axi_rdata <= {31'h00000000, conversion_end_flag_q};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Timing is counted in main clock cycles from the time-select field.
  assign total_cycles  = conv_cycles(converter_mode_reg_q[FR_HI:FR_LO]); // [RL23]
  assign sample_cycles = total_cycles / SAMPLE_DIV; // [RL16]
  assign seq_clear     = ctl_write || !conversion_start_bit || state_q == ST_IDLE;
  assign sar_step      = state_q == ST_CONV;
  assign conv_end      = state_q == ST_CONV && cnt_q == 9'h001;

  // Sequencer: optional start delay, then sample, then hold and decide.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      first_q <= 1'b0;
    end
    else if (ctl_write || !conversion_start_bit || total_cycles == '0)
    begin
      // Register writes abort; clearing start stops immediately. [RL21] [RL11]
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      first_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          state_q <= first_q ? ST_DELAY : ST_SAMPLE; // [RL4]
          cnt_q   <= first_q ? START_DELAY : sample_cycles;
        end
        ST_DELAY:
        begin
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == 9'h001)
          begin
            state_q <= ST_SAMPLE;
            cnt_q   <= sample_cycles;
            first_q <= 1'b0;
          end
        end
        ST_SAMPLE:
        begin
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == 9'h001)
          begin
            state_q <= ST_CONV;
            cnt_q   <= total_cycles - sample_cycles; // [RL4]
          end
        end
        ST_CONV:
        begin
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == 9'h001)
          begin
            // Back-to-back repeat while start stays set. [RL20]
            state_q <= ST_SAMPLE;
            cnt_q   <= sample_cycles;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  assign sample_switch  = state_q == ST_SAMPLE; // [RL16]
  assign converter_busy = state_q != ST_IDLE;

  adc_sar_core u_sar (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (seq_clear || state_q == ST_SAMPLE),
    .step      (sar_step),
    .cmp_above (cmp_sync_q),
    .approx    (approx),
    .done      (sar_done)
  );

  // Store is held off one cycle under a result read; mode or channel register writes cancel it.
  assign store_now = pend_q && !result_read;
  assign cmp_hit   = compare_direction_bit ?
                     (pend_val_q[9:2] <  power_fail_threshold_reg_q) :
                     (pend_val_q[9:2] >= power_fail_threshold_reg_q); // [RL19] [RL8]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q     <= 1'b0;
      pend_val_q <= '0;
    end
    else if (conv_write)
    begin
      pend_q <= 1'b0; // [RL13]
    end
    else if (conv_end && !ctl_write && sar_done)
    begin
      pend_q     <= 1'b1; // [RL22]
      pend_val_q <= approx;
    end
    else if (store_now)
    begin
      pend_q <= 1'b0; // [RL12]
    end
  end

  // Result register is left-aligned like the ten-bit value times 64.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conversion_result_reg_q <= RESULT_RST;
    end
    else if (store_now && !conv_write)
    begin
      conversion_result_reg_q <= {pend_val_q, 6'h00}; // [RL22]
    end
  end

  // Event pulse, gated in power-fail mode; the flag survives channel writes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q                 <= 1'b0;
      conversion_end_flag_q <= 1'b0;
    end
    else
    begin
      irq_q <= store_now && !conv_write && (!power_fail_mode_enable || cmp_hit); // [RL8]
      if (irq_q)
      begin
        conversion_end_flag_q <= 1'b1; // [RL14]
      end
      else if (wr_fire && awaddr_q == OFF_STATUS && wstrb_q[0] && wdata_q[BIT_FLAG])
      begin
        conversion_end_flag_q <= 1'b0;
      end
    end
  end

  assign conversion_end_irq = irq_q;

  // Conversion end after a control write must not store or fire.
  property p_ctl_blocks;
    @(posedge aclk) disable iff (!aresetn)
      conv_write |=> !pend_q ##1 !conversion_end_irq;
  endproperty
  AST_CTL_WINS: assert property (p_ctl_blocks) // [RL13]
    else $error("Control write did not cancel pending store.");

  // Start cleared stops the sequencer next cycle.
  AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    !conversion_start_bit |=> state_q == ST_IDLE)
    else $error("Sequencer ran with start bit clear.");

  // Sampling lasts exactly the sixth of the conversion time.
  sequence s_sample_enter;
    $rose(sample_switch) && !ctl_write;
  endsequence
  AST_SAMPLE_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    s_sample_enter |-> cnt_q == sample_cycles)
    else $error("Sample window length wrong.");

  // Power-fail gating: no event when compare condition fails.
  AST_PF_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    (store_now && !conv_write && power_fail_mode_enable && !cmp_hit)
      |=> !conversion_end_irq)
    else $error("Event fired despite failing threshold compare.");

  // Normal mode store always fires the event.
  AST_NORM_FIRE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    (store_now && !conv_write && !power_fail_mode_enable) |=> conversion_end_irq)
    else $error("Normal mode store without event.");

  // A read coinciding with a pending store delays the store by one cycle.
  AST_READ_FIRST: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
    (pend_q && result_read && !conv_write) |=> pend_q)
    else $error("Store overtook result read.");

  // Register write aborts conversion.
  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL21]
    ctl_write |=> state_q == ST_IDLE)
    else $error("Control write did not abort conversion.");

  // Flag is not cleared by a channel write.
  AST_FLAG_KEEP: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    (conversion_end_flag_q && wr_fire && awaddr_q == OFF_CHANNEL) |=> conversion_end_flag_q)
    else $error("Channel write cleared end flag.");

endmodule : adc_power_fail_sequencer

// ### bench/adc_power_fail_sequencer_tb.sv
// Self-checking testbench that drives the converter sequencer through its register bus.
`timescale 1ns/1ps
module adc_power_fail_sequencer_tb;
  import adc_seq_pkg::*;

  localparam int LIMIT = 20000;  // Whole run needs a few thousand cycles; a hang stops here.
  localparam int T6    = 96;     // Conversion cycles of time-select code 6.
  localparam int QUIET = 400;    // Longer than start delay plus one conversion.

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        cmp_above;
  logic [2:0]  channel_field;
  logic        sample_switch;
  logic        converter_power_enable;
  logic        converter_busy;
  logic        conversion_end_irq;
  int          num_errors;
  int          check_count;
  int          cyc;
  int          n;
  int          sw;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic        fire;

  adc_power_fail_sequencer u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmp_above(cmp_above),
    .channel_field(channel_field), .sample_switch(sample_switch),
    .converter_power_enable(converter_power_enable), .converter_busy(converter_busy),
    .conversion_end_irq(conversion_end_irq)
  );

  // Free-running bus clock.
  always #12.5 aclk = ~aclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Compares one data word.
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  // Compares one bus response code.
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t response got %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  // One write; address and data are each released at the edge that takes them.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    // Ready stays high afterwards, so back-to-back calls never lower and raise it at once.
    r = s_axi_bresp;
  endtask : axi_write

  // One read; ready is held until the data is sampled.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_read

  // Write that must be accepted.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    check_resp(rsp, RESP_OKAY);
  endtask : wr

  // Counts edges up to the next end event, and sampling cycles on the way.
  task automatic wait_irq(input int lim);
    n  = 0;
    sw = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (sample_switch === 1'b1)
        sw++;
    end
    while (conversion_end_irq !== 1'b1 && n < lim);
  endtask : wait_irq

  // Cuts a hang short.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // Main sequence.
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, cmp_above} = '0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Every register is zero after reset; an unmapped place is refused.
    for (int i = 0; i < 6; i++)
    begin
      axi_read(8'(4 * i), rd, rsp);
      check_word(rd, 32'h0);
    end
    axi_read(8'h18, rd, rsp);
    check_resp(rsp, RESP_SLVERR);
    // Channel first, then power, then the settling wait before start.
    wr(OFF_CHANNEL, 32'h5);
    check_word(32'(channel_field), 32'h5);
    wr(OFF_MODE, 32'h31);
    check_word(32'(converter_power_enable), 32'h1);
    // The bench has no shared port pins, so none is touched while converting.
    cmp_above <= 1'b1;
    repeat (560) @(posedge aclk);
    wr(OFF_MODE, 32'hb1);
    wait_irq(QUIET);
    wait_irq(QUIET);
    check_word(32'(n), 32'(T6));
    check_word(32'(sw), 32'(T6 / 6));
    axi_read(OFF_RESULT, rd, rsp);
    check_word(rd, 32'h0000ffc0);
    // A channel rewrite keeps the flag and restarts on the new channel.
    wr(OFF_CHANNEL, 32'h2);
    axi_read(OFF_STATUS, rd, rsp);
    check_word(rd, 32'h1);
    check_word(32'(channel_field), 32'h2);
    wait_irq(QUIET);
    check_word(32'(n > T6), 32'h1);
    wr(OFF_STATUS, 32'h1);
    axi_read(OFF_STATUS, rd, rsp);
    check_word(rd, 32'h0);
    // Power-fail gate over both directions and both sides of the threshold. Each pass
    // stops, clears the flag, sets up and starts last, with power long settled.
    for (int i = 0; i < 4; i++)
    begin
      cmp_above <= i[1];
      fire = i[0] ? ((i[1] ? 8'hff : 8'h00) < 8'h80) : ((i[1] ? 8'hff : 8'h00) >= 8'h80);
      wr(OFF_MODE, 32'h31);
      wr(OFF_STATUS, 32'h1);
      wr(OFF_PF_MODE, 32'hbf | (32'(i[0]) << 6));
      wr(OFF_PF_THRESH, 32'h80);
      wr(OFF_MODE, 32'hb1);
      wait_irq(8);
      wait_irq(QUIET);
      check_word(32'(n < QUIET), 32'(fire));
      axi_read(OFF_STATUS, rd, rsp);
      check_word(rd, 32'(fire));
    end
    axi_read(OFF_PF_MODE, rd, rsp);
    check_word(rd, 32'hc0);
    // Stop: clear start first, then power; nothing more is produced.
    wr(OFF_PF_MODE, 32'h0);
    wr(OFF_MODE, 32'h31);
    check_word(32'(converter_busy), 32'h0);
    wait_irq(QUIET);
    check_word(32'(n), 32'(QUIET));
    wr(OFF_MODE, 32'h30);
    check_word(32'(converter_power_enable), 32'h0);
    // Power and start in one write: the first result is polled for and dropped.
    wr(OFF_STATUS, 32'h1);
    wr(OFF_MODE, 32'hb1);
    wait_irq(QUIET);
    check_word(32'(n < QUIET), 32'h1);
    // A reset in mid-run clears the controls.
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_word(32'(converter_busy), 32'h0);
    axi_read(OFF_MODE, rd, rsp);
    check_word(rd, 32'h0);
    wrap_up();
  end

endmodule : adc_power_fail_sequencer_tb
